// ===== lane_test_map.svh
// Register offsets, field positions and reset values of the lane test control block
`ifndef LANE_TEST_MAP_SVH
`define LANE_TEST_MAP_SVH
`define LT_CTRL_OFFS 12'h0bc
`define LT_FAIL_OFFS 12'h0c0
`define LT_MASK_OFFS 12'h0c4
`define LT_FAIL_NUM_LANES 24
`define LT_EN_RESET 8'hff
`define LT_INV_BIT 24
`define LT_TX_PATTERN_RESYNC_BIT 25
`define LT_RX_PATTERN_RESYNC_BIT 26
`define LT_FAIL_RESET 24'h00_0000
`define LT_MASK_RESET 24'h00_0000
`endif

// ===== lane_test_pkg.sv
// Types of the lane test control block
`default_nettype none
package lane_test_pkg;
  typedef struct packed {
    logic [7:0] third_port_lane_enables;
    logic [7:0] second_port_lane_enables;
    logic [7:0] first_port_lane_enables;
  } lane_enables_t;

  typedef struct packed {
    lane_enables_t en;
    logic tx_stream_invert;
    logic [23:0] fail;
    logic [23:0] mask;
    logic [31:0] rdata;
    logic tx_resync;
    logic rx_resync;
    logic irq;
  } state_t;
endpackage : lane_test_pkg
`default_nettype wire

// ===== lane_test_ctrl.sv
// Per-lane serial test control, invert, resync and failure status
// Notes on behaviour
// - Three 8-bit lane enable fields, bit n picks lane n of a port.
// - In test mode, disabled lanes ignore receive input and hold transmit quiescent.
// - Outside test mode the lane enables change nothing.
// - Lane enable fields reset to all ones; one means enabled.
// - Invert bit flips the selected transmit stream in any mode; resets zero.
// - Writing one to tx resync in sync test mode restarts pattern generators; reads zero.
// - Writing one to rx resync in sync test mode restarts pattern checkers; reads zero.
// - Enabled lane error in test mode sets its failure flag; write one clears.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lane_test_map.svh"
module lane_test_ctrl (
  input wire logic mclk_i, // 20 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic [11:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  input wire logic test_mode_i, // Serial test mode active
  input wire logic sync_mode_i, // Test mode needs synchronisation
  input wire logic [23:0] rx_serial_i, // Received lane bits, from pins
  input wire logic [23:0] tx_stream_i, // Selected transmit stream per lane
  input wire logic [23:0] lane_error_i, // Checker error pulse per lane
  output logic [23:0] rx_lane_o, // Receive bits seen by checkers
  output logic [23:0] tx_serial_o, // Transmit bits to lanes
  output logic [23:0] lane_active_o, // Lane takes part in the test
  output logic tx_resync_o, // Pattern generator resync pulse
  output logic rx_resync_o, // Pattern checker resync pulse
  output logic irq_o // Unmasked failure pending
);
  lane_test_pkg::state_t s_q;
  lane_test_pkg::state_t s_d;
  logic [23:0] rx_meta_q;
  logic [23:0] rx_sync_q;
  logic [23:0] tx_out_q;
  logic [23:0] en_bits;
  logic [23:0] active;

  // ****************************************************
  // Lane gating
  // ****************************************************
  assign en_bits = s_q.en;

  genvar g;
  generate
    for (g = 0; g < `LT_FAIL_NUM_LANES; g++) begin : g_lane
      assign active[g] = !test_mode_i || en_bits[g];
    end
  endgenerate

  // Pin inputs pass two flops before any use
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_meta_q <= 24'h00_0000;
      rx_sync_q <= 24'h00_0000;
      tx_out_q <= 24'h00_0000;
    end else begin
      rx_meta_q <= rx_serial_i;
      rx_sync_q <= rx_meta_q;
      tx_out_q <= active & (tx_stream_i ^ {24{s_q.tx_stream_invert}});
    end
  end

  assign rx_lane_o = rx_sync_q & active;
  assign tx_serial_o = tx_out_q;
  assign lane_active_o = active;

  // ****************************************************
  // Registers
  // ****************************************************
  always_comb begin
    s_d = s_q;
    s_d.tx_resync = 1'b0;
    s_d.rx_resync = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (wr_i && addr_i == `LT_CTRL_OFFS) begin
      s_d.en = wdata_i[23:0];
      s_d.tx_stream_invert = wdata_i[`LT_INV_BIT];
      s_d.tx_resync = wdata_i[`LT_TX_PATTERN_RESYNC_BIT] && test_mode_i && sync_mode_i;
      s_d.rx_resync = wdata_i[`LT_RX_PATTERN_RESYNC_BIT] && test_mode_i && sync_mode_i;
    end
    if (wr_i && addr_i == `LT_MASK_OFFS) begin
      s_d.mask = wdata_i[23:0];
    end
    // Write one clears, new error wins
    if (wr_i && addr_i == `LT_FAIL_OFFS) begin
      s_d.fail = s_q.fail & ~wdata_i[23:0];
    end
    if (test_mode_i) begin
      s_d.fail = s_d.fail | (lane_error_i & en_bits);
    end
    if (rd_i) begin
      case (addr_i)
        // Resync bits always read zero
        `LT_CTRL_OFFS: s_d.rdata = {7'h00, s_q.tx_stream_invert, s_q.en};
        `LT_FAIL_OFFS: s_d.rdata = {8'h00, s_q.fail};
        `LT_MASK_OFFS: s_d.rdata = {8'h00, s_q.mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.irq = |(s_d.fail & s_d.mask);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '{en: '{`LT_EN_RESET, `LT_EN_RESET, `LT_EN_RESET}, tx_stream_invert: 1'b0,
               fail: `LT_FAIL_RESET, mask: `LT_MASK_RESET, rdata: 32'h0000_0000,
               tx_resync: 1'b0, rx_resync: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign tx_resync_o = s_q.tx_resync;
  assign rx_resync_o = s_q.rx_resync;
  assign irq_o = s_q.irq;
endmodule : lane_test_ctrl
`default_nettype wire

// ===== lane_test_asserts.sv
// Port assertions of the lane test control block
`timescale 1ns/100ps
`default_nettype none
module lane_test_asserts (input wire logic mclk_i, input wire logic resetn_i, input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i, input wire logic wr_i, input wire logic rd_i, input wire logic [31:0] rdata_o,
  input wire logic test_mode_i, input wire logic sync_mode_i, input wire logic [23:0] rx_lane_o,
  input wire logic [23:0] tx_serial_o, input wire logic [23:0] lane_active_o, input wire logic tx_resync_o,
  input wire logic rx_resync_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence sync_wr(int b);
    wr_i && addr_i == 12'h0bc && wdata_i[b] && test_mode_i && sync_mode_i;
  endsequence
  chk_idle_all_active: assert property (!test_mode_i |-> lane_active_o == 24'hff_ffff)
    else $error("lane idle");
  chk_rx_gated: assert property ((rx_lane_o & ~lane_active_o) == 0)
    else $error("rx leak");
  chk_tx_quiet: assert property ((tx_serial_o & ~$past(lane_active_o)) == 0)
    else $error("tx leak");
  chk_tx_pattern_resync_pulse: assert property (sync_wr(25) |=> tx_resync_o)
    else $error("no tx resync");
  chk_rx_pattern_resync_pulse: assert property (sync_wr(26) |=> rx_resync_o)
    else $error("no rx resync");
  chk_tx_pattern_resync_cause: assert property (tx_resync_o |-> $past(wr_i && wdata_i[25] && test_mode_i && sync_mode_i))
    else $error("stray tx resync");
  chk_rx_pattern_resync_cause: assert property (rx_resync_o |-> $past(wr_i && wdata_i[26] && test_mode_i && sync_mode_i))
    else $error("stray rx resync");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 0)
    else $error("read data stray");
endmodule : lane_test_asserts
`default_nettype wire

// ===== lane_far_side.sv
// Far side of the lanes: ever-changing receive levels, error pulses on request
`timescale 1ns/100ps
`default_nettype none
module lane_far_side (
  input wire logic clk_i, // Lane clock
  input wire logic [23:0] err_req_i, // Lanes to flag an error on
  output logic [23:0] rx_o = 24'h5a_5a5a, // Receive levels, never steady
  output logic [23:0] err_o = 24'h00_0000 // Error pulses, a copy of err_req_i delayed one cycle
);
  always @(posedge clk_i) begin
    rx_o <= ~rx_o;
    err_o <= err_req_i;
  end
endmodule : lane_far_side
`default_nettype wire

// ===== lane_test_ctrl_bench.sv
// Bench for the lane test control block
`timescale 1ns/100ps
`default_nettype none
module lane_test_ctrl_bench;
  logic mclk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, test_mode_i = 0, sync_mode_i = 0, tx_resync_o, rx_resync_o, irq_o;
  logic [11:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [23:0] tx_stream_i = 0, err_req = 0, rx_serial_i, lane_error_i, rx_lane_o, tx_serial_o, lane_active_o;
  int fail_count = 0, checks_done = 0;
  always #25 mclk_i = ~mclk_i;
  lane_far_side lane_far_side_inst (.clk_i(mclk_i), .err_req_i(err_req), .rx_o(rx_serial_i), .err_o(lane_error_i));
  lane_test_ctrl lane_test_ctrl_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .test_mode_i(test_mode_i), .sync_mode_i(sync_mode_i),
    .rx_serial_i(rx_serial_i), .tx_stream_i(tx_stream_i), .lane_error_i(lane_error_i), .rx_lane_o(rx_lane_o),
    .tx_serial_o(tx_serial_o), .lane_active_o(lane_active_o), .tx_resync_o(tx_resync_o),
    .rx_resync_o(rx_resync_o), .irq_o(irq_o));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i) wr_i <= 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge mclk_i) rd_i <= 0;
    #1 check(rdata_o, exp);
  endtask : rd
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1;
    rd(12'h0bc, 32'h00ff_ffff);
    rd(12'h0c8, 32'h0000_0000);
    wr(12'h0bc, 32'h07a5_5a3c);
    #1 check(tx_resync_o, 0);
    rd(12'h0bc, 32'h01a5_5a3c);
    check(lane_active_o, 32'h00ff_ffff);
    $display("register test done");
    @(posedge mclk_i) {test_mode_i, sync_mode_i} <= 2'b11;
    @(posedge mclk_i) #1 check(lane_active_o, 32'h00a5_5a3c);
    check(tx_serial_o, 32'h00a5_5a3c);
    check(rx_lane_o & 24'h5a_a5c3, 0);
    wr(12'h0bc, 32'h02a5_5a3c);
    #1 check(tx_resync_o, 1);
    wr(12'h0bc, 32'h04a5_5a3c);
    #1 check(rx_resync_o, 1);
    @(posedge mclk_i) tx_stream_i <= 24'hff_00ff;
    @(posedge mclk_i) #1 check(tx_serial_o, 32'h00a5_003c);
    wr(12'h0c4, 32'h0000_0005);
    @(posedge mclk_i) err_req <= 24'h00_0005;
    @(posedge mclk_i) err_req <= 0;
    rd(12'h0c0, 32'h0000_0004);
    check(irq_o, 1);
    wr(12'h0c0, 32'h0000_0004);
    rd(12'h0c0, 32'h0000_0000);
    check(irq_o, 0);
    wr(12'h0c4, 32'h0000_0000);
    $display("lane test done");
    final_report;
  end
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
endmodule : lane_test_ctrl_bench
bind lane_test_ctrl lane_test_asserts lane_test_asserts_inst (.*);
`default_nettype wire
